/* hdl/tbr_consts.svh */
`ifndef TBR_CONSTS_SVH
`define TBR_CONSTS_SVH
// Register index (printed) and byte address = 4 * index
`define TBR_IDX_TBCS        5'h1A
`define TBR_IDX_DTX         5'h1B
`define TBR_ADDR_TBCS       8'h68
`define TBR_ADDR_DTX        8'h6C
`define TBR_ADDR_IRQ_STAT   8'h80
`define TBR_ADDR_IRQ_CLR    8'h84
`define TBR_ADDR_IRQ_EN     8'h88
`define TBR_ADDR_SYS        8'h8C
// Control register fields
`define TBR_BIT_LINK_PULSE_OFF 7
`define TBR_BIT_FORCE_LINK     6
`define TBR_BIT_POLARITY       4
`define TBR_BIT_SQE_TEST_OFF   1
`define TBR_BIT_BABBLE_OFF     0
`define TBR_TBCS_RW_MASK       16'hFFEF
`define TBR_TBCS_RESET         16'h0804
// Extension register fields
`define TBR_DTX_RW_MASK        16'h00FF
`define TBR_DTX_RESET          16'h0000
`define TBR_BIT_NONSTOP        5
`define TBR_BIT_PATTERN_ON     4
// Interrupt status bits
`define TBR_IRQ_POL            0
`define TBR_IRQ_FAULT          1
`define TBR_IRQ_SAT            2
`define TBR_IRQ_W              3
`endif

/* hdl/tbr_pkg.sv */
`default_nettype none
package tbr_pkg;
    typedef enum logic [1:0] {
        TBR_PAT_EOP0 = 2'h0,
        TBR_PAT_EOP1 = 2'h1,
        TBR_PAT_NLP  = 2'h2,
        TBR_PAT_MAN1 = 2'h3
    } tbr_pattern_t;
    typedef struct packed {
        logic         link_pulse_off;
        logic         force_link_good;
        logic         sqe_test_on;
        logic         babble_guard_on;
        logic         selftest_nonstop;
        logic         driver_pattern_on;
        tbr_pattern_t driver_pattern_choice;
    } tbr_ctl_t;
endpackage
`default_nettype wire

/* hdl/tbr_regs.sv */
// ==========================================================
// Summary of operation
// - Link pulse off bit stops link pulses
// - Cleared bit keeps link pulses running
// - Bit 6 forces 10 Mb link good
// - Bit 4 reports latched inverted polarity
// - Control read clears both polarity copies
// - Bit 1 disables heartbeat in 10 half
// - Heartbeat off at 100 Mb or full
// - Bit 0 disables jabber, 10BASE-T only
// - Bits 15:8 count errored self-test nibbles
// - Tally clears when self-test restarts
// - Tally saturates at maximum count
// - Bit 5 makes self-test transmit continuously
// - Nonstop acts only with self-test enabled
// - Bit 4 enables driver test pattern
// - Selector picks EOP0, EOP1, pulses, Manchester
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tbr_consts.svh"
module tbr_regs #(
    parameter int TALLY_W = 8
) (
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RSTN,
    // AXI4-Lite write address / data / response
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // PHY status inputs (asynchronous)
    input  wire logic              POL_INVERTED,
    input  wire logic              SPEED_100,
    input  wire logic              FULL_DUPLEX,
    input  wire logic              SELFTEST_RUN,
    input  wire logic              SELFTEST_NIBBLE_ERR,
    // Controls to the 10BASE-T datapath
    output logic                   LINK_PULSE_EN,
    output logic                   FORCE_LINK_GOOD,
    output logic                   SQE_TEST_EN,
    output logic                   BABBLE_GUARD_EN,
    output logic                   SELFTEST_NONSTOP_EN,
    output logic                   DRIVER_PATTERN_EN,
    output logic [1:0]             DRIVER_PATTERN_SEL,
    output logic                   POL_SUMMARY,
    // Interrupt
    output logic                   IRQ
);
    // ==========================================================
    // Input synchronisers
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {POL_INVERTED, SPEED_100, FULL_DUPLEX, SELFTEST_RUN, SELFTEST_NIBBLE_ERR};
            sync2_r <= sync1_r;
        end
    end
    logic pol_s, spd_s, fdx_s, run_s, err_s;
    assign {pol_s, spd_s, fdx_s, run_s, err_s} = sync2_r;
    logic run_d_r;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run_s;
        end
    end
    logic run_start;
    assign run_start = run_s && !run_d_r;

    // ==========================================================
    // AXI4-Lite write channel
    logic        aw_held_r, w_held_r, wr_go, wr_hit;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    assign S_AXI_AWREADY = !aw_held_r && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held_r && !S_AXI_BVALID;
    assign wr_go         = aw_held_r && w_held_r && !S_AXI_BVALID;
    assign S_AXI_RRESP   = 2'h0;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= 32'h00000000;
            wstrb_r      <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= 2'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                wdata_r  <= S_AXI_WDATA;
                wstrb_r  <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? 2'h0 : 2'h2;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end
    // Full address match, so the response agrees with whether the write lands
    assign wr_hit = awaddr_r == `TBR_ADDR_TBCS || awaddr_r == `TBR_ADDR_DTX
                 || awaddr_r == `TBR_ADDR_IRQ_CLR || awaddr_r == `TBR_ADDR_IRQ_EN;
    logic [15:0] wmask;
    assign wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    logic wr_tbcs, wr_dtx, wr_clr, wr_en;
    assign wr_tbcs = wr_go && awaddr_r == `TBR_ADDR_TBCS;
    assign wr_dtx  = wr_go && awaddr_r == `TBR_ADDR_DTX;
    assign wr_clr  = wr_go && awaddr_r == `TBR_ADDR_IRQ_CLR;
    assign wr_en   = wr_go && awaddr_r == `TBR_ADDR_IRQ_EN;

    // ==========================================================
    // Control registers; reserved bits are stored as written
    logic [15:0] tbcs_r;
    logic [15:0] dtx_r;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tbcs_r <= `TBR_TBCS_RESET;
            dtx_r  <= `TBR_DTX_RESET;
        end else begin
            if (wr_tbcs) begin
                tbcs_r <= (tbcs_r & ~wmask) | (wdata_r[15:0] & wmask & `TBR_TBCS_RW_MASK);
            end
            if (wr_dtx) begin
                dtx_r <= (dtx_r & ~wmask) | (wdata_r[15:0] & wmask & `TBR_DTX_RW_MASK);
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic rd_tbcs;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_tbcs = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `TBR_ADDR_TBCS;
    logic [TALLY_W-1:0] tally_r;
    logic               pol_r, pol_sum_r;
    logic [`TBR_IRQ_W-1:0] irq_stat_r;
    logic [`TBR_IRQ_W-1:0] irq_en_r;
    logic [15:0] tbcs_view;
    assign tbcs_view = {tbcs_r[15:5], pol_r, tbcs_r[3:0]};
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
        end else begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                unique case (S_AXI_ARADDR)
                    `TBR_ADDR_TBCS:     S_AXI_RDATA <= {16'h0000, tbcs_view};
                    `TBR_ADDR_DTX:      S_AXI_RDATA <= {16'h0000, tally_r, dtx_r[7:0]};
                    `TBR_ADDR_IRQ_STAT: S_AXI_RDATA <= {29'h0, irq_stat_r};
                    `TBR_ADDR_IRQ_EN:   S_AXI_RDATA <= {29'h0, irq_en_r};
                    `TBR_ADDR_SYS:      S_AXI_RDATA <= {31'h0, pol_sum_r};
                    default:            S_AXI_RDATA <= 32'h00000000;
                endcase
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Latched polarity copies; detection wins over the clearing read
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pol_r     <= 1'b0;
            pol_sum_r <= 1'b0;
        end else begin
            if (pol_s) begin
                pol_r     <= 1'b1;
                pol_sum_r <= 1'b1;
            end else if (rd_tbcs) begin
                pol_r     <= 1'b0;
                pol_sum_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Self-test error tally
    logic tally_max;
    assign tally_max = &tally_r;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tally_r <= '0;
        end else if (run_start) begin
            tally_r <= '0;
        end else if (run_s && err_s && !tally_max) begin
            tally_r <= tally_r + 1'b1;
        end
    end

    // ==========================================================
    // Interrupts: polarity, nibble fault, tally saturated
    logic [`TBR_IRQ_W-1:0] ev;
    assign ev = {run_s && err_s && tally_r == {{(TALLY_W-1){1'b1}}, 1'b0}, run_s && err_s, pol_s && !pol_r};
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_stat_r <= '0;
            irq_en_r   <= '0;
            IRQ        <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_clr ? wdata_r[`TBR_IRQ_W-1:0] : '0)) | ev;
            if (wr_en) begin
                irq_en_r <= wdata_r[`TBR_IRQ_W-1:0];
            end
            IRQ <= |(irq_stat_r & irq_en_r);
        end
    end

    // ==========================================================
    // Controls to the datapath
    tbr_pkg::tbr_ctl_t ctl;
    always_comb begin
        ctl.link_pulse_off        = tbcs_r[`TBR_BIT_LINK_PULSE_OFF];
        ctl.force_link_good       = tbcs_r[`TBR_BIT_FORCE_LINK];
        ctl.sqe_test_on           = !tbcs_r[`TBR_BIT_SQE_TEST_OFF] && !spd_s && !fdx_s;
        ctl.babble_guard_on       = !tbcs_r[`TBR_BIT_BABBLE_OFF] && !spd_s;
        ctl.selftest_nonstop      = dtx_r[`TBR_BIT_NONSTOP] && run_s;
        ctl.driver_pattern_on     = dtx_r[`TBR_BIT_PATTERN_ON];
        ctl.driver_pattern_choice = tbr_pkg::tbr_pattern_t'(dtx_r[1:0]);
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            LINK_PULSE_EN       <= 1'b1;
            FORCE_LINK_GOOD     <= 1'b0;
            SQE_TEST_EN         <= 1'b0;
            BABBLE_GUARD_EN     <= 1'b0;
            SELFTEST_NONSTOP_EN <= 1'b0;
            DRIVER_PATTERN_EN   <= 1'b0;
            DRIVER_PATTERN_SEL  <= 2'h0;
            POL_SUMMARY         <= 1'b0;
        end else begin
            LINK_PULSE_EN       <= !ctl.link_pulse_off;
            FORCE_LINK_GOOD     <= ctl.force_link_good;
            SQE_TEST_EN         <= ctl.sqe_test_on;
            BABBLE_GUARD_EN     <= ctl.babble_guard_on;
            SELFTEST_NONSTOP_EN <= ctl.selftest_nonstop;
            DRIVER_PATTERN_EN   <= ctl.driver_pattern_on;
            DRIVER_PATTERN_SEL  <= ctl.driver_pattern_choice;
            POL_SUMMARY         <= pol_sum_r;
        end
    end

    // ==========================================================
    // Assertions
    property p_lp;
        @(posedge REF_CLK) disable iff (!RSTN) $rose(tbcs_r[7]) |=> !LINK_PULSE_EN;
    endproperty
    a_lp: assert property (p_lp) else $error("link pulses not stopped");
    property p_lp_on;
        @(posedge REF_CLK) disable iff (!RSTN) !tbcs_r[7] |=> LINK_PULSE_EN;
    endproperty
    a_lp_on: assert property (p_lp_on) else $error("link pulses off while enabled");
    property p_force;
        @(posedge REF_CLK) disable iff (!RSTN) 1'b1 |=> FORCE_LINK_GOOD == $past(tbcs_r[6]);
    endproperty
    a_force: assert property (p_force) else $error("force link mismatch");
    property p_polset;
        @(posedge REF_CLK) disable iff (!RSTN) pol_s |=> pol_r && pol_sum_r;
    endproperty
    a_polset: assert property (p_polset) else $error("polarity not latched");
    sequence s_pol_cleared;
        !pol_r ##1 !POL_SUMMARY;
    endsequence
    property p_polclr;
        @(posedge REF_CLK) disable iff (!RSTN) rd_tbcs && !pol_s |=> s_pol_cleared;
    endproperty
    a_polclr: assert property (p_polclr) else $error("polarity not cleared by read");
    property p_sqe;
        @(posedge REF_CLK) disable iff (!RSTN) (spd_s || fdx_s) |=> !SQE_TEST_EN;
    endproperty
    a_sqe: assert property (p_sqe) else $error("heartbeat on at 100M or full");
    property p_sqeoff;
        @(posedge REF_CLK) disable iff (!RSTN) tbcs_r[1] |=> !SQE_TEST_EN;
    endproperty
    a_sqeoff: assert property (p_sqeoff) else $error("heartbeat on while disabled");
    property p_jab;
        @(posedge REF_CLK) disable iff (!RSTN) tbcs_r[0] |=> !BABBLE_GUARD_EN;
    endproperty
    a_jab: assert property (p_jab) else $error("jabber on while disabled");
    property p_restart;
        @(posedge REF_CLK) disable iff (!RSTN) run_start |=> tally_r == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("tally not cleared on restart");
    property p_sat;
        @(posedge REF_CLK) disable iff (!RSTN) tally_max && !run_start |=> tally_max;
    endproperty
    a_sat: assert property (p_sat) else $error("tally wrapped");
    property p_count;
        @(posedge REF_CLK) disable iff (!RSTN) run_s && err_s && !run_start && !tally_max
            |=> tally_r == $past(tally_r) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("tally missed error");
    property p_nonstop;
        @(posedge REF_CLK) disable iff (!RSTN) !run_s |=> !SELFTEST_NONSTOP_EN;
    endproperty
    a_nonstop: assert property (p_nonstop) else $error("nonstop without self-test");
    property p_pat;
        @(posedge REF_CLK) disable iff (!RSTN) 1'b1
            |=> DRIVER_PATTERN_EN == $past(dtx_r[4]) && DRIVER_PATTERN_SEL == $past(dtx_r[1:0]);
    endproperty
    a_pat: assert property (p_pat) else $error("pattern controls mismatch");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbr_consts.svh"
// ==========================================================
// Register bank bench
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, pat_sel;
    logic [31:0] rdata;
    logic        pol_inv = 1'b0, speed = 1'b0, fdx = 1'b0, run = 1'b0, nib_err = 1'b0;
    logic        lp_en, force_good, sqe_en, babble_en, nonstop_en, pat_en, pol_sum, irq;
    logic [31:0] rq[$];
    logic [1:0]  bq[$];
    int          failures = 0;
    int          cmp_count = 0;

    always #5 ref_clk = ~ref_clk;

    tbr_regs dut (
        .REF_CLK(ref_clk), .RSTN(rstn),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .POL_INVERTED(pol_inv), .SPEED_100(speed), .FULL_DUPLEX(fdx),
        .SELFTEST_RUN(run), .SELFTEST_NIBBLE_ERR(nib_err),
        .LINK_PULSE_EN(lp_en), .FORCE_LINK_GOOD(force_good), .SQE_TEST_EN(sqe_en),
        .BABBLE_GUARD_EN(babble_en), .SELFTEST_NONSTOP_EN(nonstop_en),
        .DRIVER_PATTERN_EN(pat_en), .DRIVER_PATTERN_SEL(pat_sel), .POL_SUMMARY(pol_sum), .IRQ(irq)
    );

    // ==========================================================
    // Checking
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Responses are matched against the oldest note left by the driver
    always @(posedge ref_clk) begin
        if (rvalid && rready) begin
            check("rdata", rdata, (rq.size() > 0) ? rq.pop_front() : 32'hDEAD_BEEF);
            check("rresp", {30'h0, rresp}, 32'h0);
        end
        if (bvalid && bready)
            check("bresp", {30'h0, bresp}, {30'h0, (bq.size() > 0) ? bq.pop_front() : 2'h3});
    end

    // ==========================================================
    // Bus tasks
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] resp);
        int n;
        bq.push_back(resp);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) bready <= 1'b0;
        end while ((awvalid || wvalid || bready) && n < 100);
        if (n >= 100) failures++;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        int n;
        rq.push_back(exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) rready <= 1'b0;
        end while ((arvalid || rready) && n < 100);
        if (n >= 100) failures++;
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        logic [15:0] v;
        int          k;
        v = 16'($urandom(32'hE550C6D3));
        wait_clk(4);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(`TBR_ADDR_TBCS, 32'h0000_0804);
        rd(`TBR_ADDR_DTX, 32'h0000_0000);
        wait_clk(4);
        check("lp_en", {31'h0, lp_en}, 32'h1);
        check("force", {31'h0, force_good}, 32'h0);
        check("sqe", {31'h0, sqe_en}, 32'h1);
        check("babble", {31'h0, babble_en}, 32'h1);
        check("pat_en", {31'h0, pat_en}, 32'h0);
        // Bit 4 is read-only, so the written one must not stick
        wr(`TBR_ADDR_TBCS, 16'h08D7, 2'h0);
        wait_clk(4);
        check("lp_en", {31'h0, lp_en}, 32'h0);
        check("force", {31'h0, force_good}, 32'h1);
        check("sqe", {31'h0, sqe_en}, 32'h0);
        check("babble", {31'h0, babble_en}, 32'h0);
        rd(`TBR_ADDR_TBCS, 32'h0000_08C7);
        wr(`TBR_ADDR_TBCS, 16'h0804, 2'h0);
        for (k = 0; k < 4; k++) begin
            speed <= k[0];
            fdx <= k[1];
            wait_clk(6);
            check("sqe_mode", {31'h0, sqe_en}, {31'h0, k == 0});
            check("babble_mode", {31'h0, babble_en}, {31'h0, !k[0]});
        end
        speed <= 1'b0;
        fdx <= 1'b0;
        wr(`TBR_ADDR_IRQ_EN, 16'h0001, 2'h0);
        pol_inv <= 1'b1;
        wait_clk(3);
        pol_inv <= 1'b0;
        wait_clk(6);
        check("pol_sum", {31'h0, pol_sum}, 32'h1);
        check("irq", {31'h0, irq}, 32'h1);
        rd(`TBR_ADDR_SYS, 32'h0000_0001);
        rd(`TBR_ADDR_SYS, 32'h0000_0001);
        rd(`TBR_ADDR_TBCS, 32'h0000_0814);
        rd(`TBR_ADDR_TBCS, 32'h0000_0804);
        wait_clk(3);
        check("pol_sum_clr", {31'h0, pol_sum}, 32'h0);
        rd(`TBR_ADDR_IRQ_STAT, 32'h0000_0001);
        wr(`TBR_ADDR_IRQ_CLR, 16'h0001, 2'h0);
        wait_clk(3);
        check("irq_clr", {31'h0, irq}, 32'h0);
        // Jabber guard off before any nonstop use at 10 Mb
        wr(`TBR_ADDR_TBCS, 16'h0805, 2'h0);
        run <= 1'b1;
        wait_clk(4);
        k = 1 + $urandom_range(19);
        nib_err <= 1'b1;
        wait_clk(k);
        nib_err <= 1'b0;
        wait_clk(5);
        rd(`TBR_ADDR_DTX, {16'h0, k[7:0], 8'h00});
        rd(`TBR_ADDR_IRQ_STAT, 32'h0000_0002);
        check("irq_masked", {31'h0, irq}, 32'h0);
        nib_err <= 1'b1;
        wait_clk(300);
        nib_err <= 1'b0;
        wait_clk(5);
        rd(`TBR_ADDR_DTX, 32'h0000_FF00);
        run <= 1'b0;
        wait_clk(4);
        wr(`TBR_ADDR_DTX, 16'h0020, 2'h0);
        wait_clk(4);
        check("nonstop_idle", {31'h0, nonstop_en}, 32'h0);
        run <= 1'b1;
        wait_clk(6);
        check("nonstop_run", {31'h0, nonstop_en}, 32'h1);
        rd(`TBR_ADDR_DTX, 32'h0000_0020);
        for (k = 0; k < 4; k++) begin
            v = 16'($urandom);
            v[4] = 1'b1;
            // Reserved extension bits 7:6 are kept at zero
            v[7:6] = 2'b00;
            v[1:0] = k[1:0];
            wr(`TBR_ADDR_DTX, v, 2'h0);
            wait_clk(4);
            rd(`TBR_ADDR_DTX, {24'h0, v[7:0]});
            check("pat_en", {31'h0, pat_en}, 32'h1);
            check("pat_sel", {30'h0, pat_sel}, {30'h0, k[1:0]});
            check("nonstop", {31'h0, nonstop_en}, {31'h0, v[5]});
        end
        wr(8'h40, 16'h1234, 2'h2);
        rd(8'h40, 32'h0000_0000);
        wait_clk(5);
        results();
    end

    // Whole run is under 520 cycles; over thirty-eight times that is a hang
    initial begin
        #200000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
